/* File: logic/bus_zone_pkg.sv */
// bus_zone_pkg: offsets, field layout, reset values and cycle counts of the
// bus zone timing block.
// assumes a byte-addressed Avalon-MM slave window of 32-bit words.
package bus_zone_pkg;

   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [4:0] OFS_WRITE_MODE  = 5'h00;
   localparam logic [4:0] OFS_IO_ZONE     = 5'h04;
   localparam logic [4:0] OFS_FLASH_ZONE  = 5'h08;
   localparam logic [4:0] OFS_EXT_ZONE    = 5'h0C;
   localparam logic [4:0] OFS_STATUS      = 5'h10;

   // ----------------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------------
   localparam logic [7:0]  WRITE_MODE_RESET = 8'h07;
   localparam logic [7:0]  WRITE_MODE_MASK  = 8'h01;
   localparam logic [15:0] ZONE_CFG_RESET   = 16'h069F;
   localparam logic [15:0] ZONE_CFG_MASK    = 16'h0EFF;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int EARLY_WRITE_BIT = 0;
   localparam int WAIT_LSB        = 0;
   localparam int HOLD_LSB        = 3;
   localparam int BURST_EN_BIT    = 5;
   localparam int BURST_WAIT_BIT  = 6;
   localparam int WIDTH_BIT       = 7;
   localparam int POST_IDLE_BIT   = 9;
   localparam int PRE_IDLE_BIT    = 10;
   localparam int FAST_READ_BIT   = 11;

   // ----------------------------------------------------------------------
   // zone codes on the core bus and basic cycle lengths
   // ----------------------------------------------------------------------
   localparam logic [1:0] ZONE_FLASH = 2'h0;
   localparam logic [1:0] ZONE_EXT   = 2'h1;
   localparam logic [1:0] ZONE_IO    = 2'h2;
   localparam logic [1:0] ZONE_NONE  = 2'h3;

   localparam logic [2:0] BASE_READ_CYCLES   = 3'h2;
   localparam logic [2:0] BASE_LATE_CYCLES   = 3'h2;
   localparam logic [2:0] BASE_EARLY_CYCLES  = 3'h3;

endpackage : bus_zone_pkg

/* File: logic/bus_zone_timing_config.sv */
// bus_zone_timing_config: zone timing registers behind an Avalon-MM slave
// and the sequencer that shapes each core bus cycle from them.
// assumes the core holds core_req and its qualifiers until core_done.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps

// Function
// - write mode register resets to 07h
// - bit 0 picks early or late write
// - io zone register, 16 bits, resets 069Fh
// - wait field adds zero to seven waits
// - hold field adds zero to three holds
// - fast read disables wait and hold; the io zone decoder ignores its fast read bit (HAS_FAST_BURST = 0)
// - fast read one cycle, normal two plus
// - width bit selects 8 or 16 bits
// - burst read for wide reads, gated; the io zone decoder never bursts (HAS_FAST_BURST = 0)
// - burst wait adds one burst cycle
// - post idle before a different zone
// - pre idle after a different zone
// - flash zone register resets 069Fh
// - external zone one register resets 069Fh
// - waits follow address, holds end cycle
// - base read 2, late 2, early 3
module bus_zone_timing_config
   import bus_zone_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // core bus request
   input  wire logic        core_req,
   input  wire logic        core_write,
   input  wire logic        core_wide,
   input  wire logic [1:0]  core_zone,
   output logic             core_done,
   // bus cycle phases
   output logic             zone_one_chip_select,
   output logic             addr_phase,
   output logic             internal_wait_cycle,
   output logic             burst_wait_cycle,
   output logic             hold_phase,
   output logic             idle_phase
);

   // ----------------------------------------------------------------------
   // registers and bus slave
   // ----------------------------------------------------------------------
   logic [7:0]  write_cycle_mode_cfg_r;
   logic [15:0] io_zone_timing_cfg_r;
   logic [15:0] flash_zone_timing_cfg_r;
   logic [15:0] ext_zone_one_timing_cfg_r;
   logic        ack_r;
   logic        wr_take;
   logic [15:0] wdata16;
   logic [7:0]  last_len_r;
   logic [1:0]  last_zone_r;
   logic        busy;

   // one wait cycle per access; the request is taken when ack_r is high
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_take = avs_write & ack_r;

   always_ff @(posedge clk) begin
      if (!reset_n)
         ack_r <= 1'b0;
      else
         ack_r <= (avs_read | avs_write) & ~ack_r;
   end

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be,
                                           input logic [15:0] mask);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}} & mask;
      merge16 = (old_v & ~m) | (new_v & m);
   endfunction : merge16

   assign wdata16 = avs_writedata[15:0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         write_cycle_mode_cfg_r    <= WRITE_MODE_RESET;
         io_zone_timing_cfg_r      <= ZONE_CFG_RESET;
         flash_zone_timing_cfg_r   <= ZONE_CFG_RESET;
         ext_zone_one_timing_cfg_r <= ZONE_CFG_RESET;
      end else if (wr_take) begin
         case (avs_address)
            OFS_WRITE_MODE: begin
               if (avs_byteenable[0])
                  write_cycle_mode_cfg_r <= (write_cycle_mode_cfg_r & ~WRITE_MODE_MASK)
                                            | (avs_writedata[7:0] & WRITE_MODE_MASK);
            end
            OFS_IO_ZONE:    io_zone_timing_cfg_r <= merge16(io_zone_timing_cfg_r,
                               wdata16, avs_byteenable[1:0], ZONE_CFG_MASK);
            OFS_FLASH_ZONE: flash_zone_timing_cfg_r <= merge16(flash_zone_timing_cfg_r,
                               wdata16, avs_byteenable[1:0], ZONE_CFG_MASK);
            OFS_EXT_ZONE:   ext_zone_one_timing_cfg_r <= merge16(ext_zone_one_timing_cfg_r,
                               wdata16, avs_byteenable[1:0], ZONE_CFG_MASK);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read & ~ack_r) begin
         case (avs_address)
            OFS_WRITE_MODE: avs_readdata <= {24'h00_0000, write_cycle_mode_cfg_r};
            OFS_IO_ZONE:    avs_readdata <= {16'h0000, io_zone_timing_cfg_r};
            OFS_FLASH_ZONE: avs_readdata <= {16'h0000, flash_zone_timing_cfg_r};
            OFS_EXT_ZONE:   avs_readdata <= {16'h0000, ext_zone_one_timing_cfg_r};
            OFS_STATUS:     avs_readdata <= {21'h00_0000, busy, last_zone_r, last_len_r};
            default:        avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // per-zone timing decode
   // ----------------------------------------------------------------------
   logic       is_read;
   logic       z_fast      [3];
   logic [2:0] z_wait      [3];
   logic [1:0] z_hold      [3];
   logic       z_burst     [3];
   logic       z_bwait     [3];
   logic       z_split     [3];
   logic       z_pre       [3];
   logic       z_post      [3];

   assign is_read = ~core_write;

   zone_timing_decode #(.HAS_FAST_BURST(1'b1), .BURST_NEEDS_WIDE(1'b0)) u_flash (
      .cfg(flash_zone_timing_cfg_r), .is_read(is_read), .wide_access(core_wide),
      .fast(z_fast[0]), .wait_n(z_wait[0]), .hold_n(z_hold[0]), .burst(z_burst[0]),
      .burst_wait(z_bwait[0]), .split(z_split[0]), .pre_idle(z_pre[0]),
      .post_idle(z_post[0]));

   zone_timing_decode #(.HAS_FAST_BURST(1'b1), .BURST_NEEDS_WIDE(1'b1)) u_ext (
      .cfg(ext_zone_one_timing_cfg_r), .is_read(is_read), .wide_access(core_wide),
      .fast(z_fast[1]), .wait_n(z_wait[1]), .hold_n(z_hold[1]), .burst(z_burst[1]),
      .burst_wait(z_bwait[1]), .split(z_split[1]), .pre_idle(z_pre[1]),
      .post_idle(z_post[1]));

   zone_timing_decode #(.HAS_FAST_BURST(1'b0), .BURST_NEEDS_WIDE(1'b1)) u_io (
      .cfg(io_zone_timing_cfg_r), .is_read(is_read), .wide_access(core_wide),
      .fast(z_fast[2]), .wait_n(z_wait[2]), .hold_n(z_hold[2]), .burst(z_burst[2]),
      .burst_wait(z_bwait[2]), .split(z_split[2]), .pre_idle(z_pre[2]),
      .post_idle(z_post[2]));

   // ----------------------------------------------------------------------
   // bus cycle sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_GAP, S_ADDR, S_WAIT, S_DATA, S_BURST, S_HOLD, S_DONE
   } seq_state_t;

   seq_state_t  state_r;
   logic [2:0]  cnt_r;
   logic [1:0]  zone_r;
   logic        fast_r;
   logic [2:0]  wait_r;
   logic [1:0]  hold_r;
   logic        burst_r;
   logic        bwait_r;
   logic        second_r;
   logic        split_r;
   logic [2:0]  data_len_r;
   logic        post_r;
   logic        last_valid_r;
   logic [7:0]  len_r;
   logic        sel_zone;
   logic [1:0]  zi;
   logic        gap_post;
   logic        gap_pre;
   logic [2:0]  base_len;
   logic        early;

   assign sel_zone = (core_zone != ZONE_NONE);
   assign zi       = sel_zone ? core_zone : ZONE_FLASH;
   assign early    = write_cycle_mode_cfg_r[EARLY_WRITE_BIT];
   assign base_len = is_read ? BASE_READ_CYCLES
                   : (early ? BASE_EARLY_CYCLES : BASE_LATE_CYCLES);
   assign gap_post = last_valid_r & post_r & (core_zone != last_zone_r);
   assign gap_pre  = sel_zone & z_pre[zi] & last_valid_r
                     & (core_zone != last_zone_r);
   assign busy     = (state_r != S_IDLE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r    <= S_IDLE;
         cnt_r      <= 3'h0;
         zone_r     <= ZONE_NONE;
         fast_r     <= 1'b0;
         wait_r     <= 3'h0;
         hold_r     <= 2'h0;
         burst_r    <= 1'b0;
         bwait_r    <= 1'b0;
         split_r    <= 1'b0;
         second_r   <= 1'b0;
         data_len_r <= 3'h0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (core_req) begin
                  zone_r     <= core_zone;
                  second_r   <= 1'b0;
                  fast_r     <= sel_zone & z_fast[zi];
                  wait_r     <= sel_zone ? z_wait[zi] : 3'h0;
                  hold_r     <= sel_zone ? z_hold[zi] : 2'h0;
                  burst_r    <= sel_zone & z_burst[zi];
                  bwait_r    <= sel_zone & z_bwait[zi];
                  split_r    <= sel_zone & z_split[zi];
                  // data phase length: base less the address cycle
                  data_len_r <= base_len - 3'h1;
                  if (gap_post | gap_pre) begin
                     cnt_r   <= 3'({2'h0, gap_post} + {2'h0, gap_pre});
                     state_r <= S_GAP;
                  end else begin
                     state_r <= S_ADDR;
                  end
               end
            end
            S_GAP: begin
               if (cnt_r == 3'h1)
                  state_r <= S_ADDR;
               cnt_r <= cnt_r - 3'h1;
            end
            S_ADDR: begin
               if (fast_r) begin
                  state_r <= S_DONE;
               end else if (wait_r != 3'h0) begin
                  cnt_r   <= wait_r;
                  state_r <= S_WAIT;
               end else begin
                  cnt_r   <= data_len_r;
                  state_r <= S_DATA;
               end
            end
            S_WAIT: begin
               if (cnt_r == 3'h1) begin
                  cnt_r   <= data_len_r;
                  state_r <= S_DATA;
               end else begin
                  cnt_r <= cnt_r - 3'h1;
               end
            end
            S_DATA: begin
               if (cnt_r > 3'h1) begin
                  cnt_r <= cnt_r - 3'h1;
               end else if (burst_r) begin
                  cnt_r   <= bwait_r ? 3'h2 : 3'h1;
                  state_r <= S_BURST;
               end else if (hold_r != 2'h0) begin
                  cnt_r   <= {1'b0, hold_r};
                  state_r <= S_HOLD;
               end else if (split_r & ~second_r) begin
                  second_r <= 1'b1;
                  state_r  <= S_ADDR;
               end else begin
                  state_r <= S_DONE;
               end
            end
            S_BURST: begin
               if (cnt_r > 3'h1) begin
                  cnt_r <= cnt_r - 3'h1;
               end else if (hold_r != 2'h0) begin
                  cnt_r   <= {1'b0, hold_r};
                  state_r <= S_HOLD;
               end else begin
                  state_r <= S_DONE;
               end
            end
            S_HOLD: begin
               if (cnt_r > 3'h1) begin
                  cnt_r <= cnt_r - 3'h1;
               end else if (split_r & ~second_r) begin
                  second_r <= 1'b1;
                  state_r  <= S_ADDR;
               end else begin
                  state_r <= S_DONE;
               end
            end
            S_DONE: state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // history of the last cycle and its length
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         last_zone_r  <= ZONE_NONE;
         last_valid_r <= 1'b0;
         post_r       <= 1'b0;
         len_r        <= 8'h00;
         last_len_r   <= 8'h00;
      end else if (state_r == S_DONE) begin
         last_zone_r  <= zone_r;
         last_valid_r <= 1'b1;
         post_r       <= (zone_r != ZONE_NONE) & z_post[zone_r == ZONE_NONE ? 2'h0 : zone_r];
         last_len_r   <= len_r;
         len_r        <= 8'h00;
      end else if (state_r != S_IDLE && state_r != S_GAP) begin
         len_r <= len_r + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // phase outputs
   // ----------------------------------------------------------------------
   assign core_done            = (state_r == S_DONE);
   assign addr_phase           = (state_r == S_ADDR);
   assign internal_wait_cycle  = (state_r == S_WAIT);
   assign burst_wait_cycle     = (state_r == S_BURST) & bwait_r & (cnt_r == 3'h2);
   assign hold_phase           = (state_r == S_HOLD);
   assign idle_phase           = (state_r == S_GAP);
   assign zone_one_chip_select = (zone_r == ZONE_EXT) & (state_r == S_ADDR
                                 || state_r == S_WAIT || state_r == S_DATA
                                 || state_r == S_BURST || state_r == S_HOLD);

endmodule : bus_zone_timing_config

/* File: logic/zone_timing_decode.sv */
// zone_timing_decode: turns one zone timing word and the kind of access into
// the effective wait, hold, burst and idle settings for the sequencer.
// assumes the timing word is already masked to its writable bits.
`timescale 1ns/1ps
module zone_timing_decode
   import bus_zone_pkg::*;
#(
   parameter bit HAS_FAST_BURST = 1'b1,
   parameter bit BURST_NEEDS_WIDE = 1'b1
) (
   input  wire logic [15:0] cfg,
   input  wire logic        is_read,
   input  wire logic        wide_access,
   output logic             fast,
   output logic [2:0]       wait_n,
   output logic [1:0]       hold_n,
   output logic             burst,
   output logic             burst_wait,
   output logic             split,
   output logic             pre_idle,
   output logic             post_idle
);

   logic fast_en;
   logic width16;

   assign fast_en   = HAS_FAST_BURST & cfg[FAST_READ_BIT];
   assign width16   = cfg[WIDTH_BIT];
   // fast read finishes in one cycle; wait and hold are then ignored
   assign fast      = fast_en & is_read;
   assign wait_n    = fast_en ? 3'h0 : cfg[WAIT_LSB +: 3];
   assign hold_n    = fast_en ? 2'h0 : cfg[HOLD_LSB +: 2];
   assign burst     = HAS_FAST_BURST & cfg[BURST_EN_BIT] & ~fast_en
                      & is_read & wide_access
                      & (width16 | ~BURST_NEEDS_WIDE);
   assign burst_wait = burst & cfg[BURST_WAIT_BIT];
   // a 16-bit access to an 8-bit zone without burst or fast read runs as two cycles
   assign split     = wide_access & ~width16 & ~burst & ~fast;
   assign pre_idle  = cfg[PRE_IDLE_BIT];
   assign post_idle = cfg[POST_IDLE_BIT];

endmodule : zone_timing_decode

/* File: verification/bus_zone_chk.sv */
// bus_zone_chk: port-level assertions for the bus zone timing block.
// assumes it is bound to bus_zone_timing_config and sees its ports only.
`timescale 1ns/1ps
module bus_zone_chk
   import bus_zone_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       core_req,
   input wire logic [1:0] core_zone,
   input wire logic       core_done,
   input wire logic       zone_one_chip_select,
   input wire logic       addr_phase,
   input wire logic       internal_wait_cycle,
   input wire logic       burst_wait_cycle,
   input wire logic       hold_phase,
   input wire logic       idle_phase
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------------
   sequence s_reg_answer;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence s_wait_run;
      internal_wait_cycle [*7];
   endsequence
   sequence s_hold_run;
      hold_phase [*3];
   endsequence
   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   a_reg_one_wait: assert property ($rose(avs_read || avs_write) |-> s_reg_answer)
      else $error("register access not answered after one wait");
   a_done_pulse: assert property (core_done |=> !core_done)
      else $error("done longer than one cycle");
   a_cs_own_zone: assert property (zone_one_chip_select |-> core_zone == ZONE_EXT)
      else $error("chip select outside zone one");
   a_wait_after_addr: assert property ($rose(internal_wait_cycle) |-> $past(addr_phase))
      else $error("wait not right after address");
   a_wait_bound: assert property (s_wait_run |=> !internal_wait_cycle)
      else $error("more than seven waits");
   a_hold_bound: assert property (s_hold_run |=> !hold_phase)
      else $error("more than three holds");
   a_hold_ends: assert property ($fell(hold_phase) |-> core_done || addr_phase)
      else $error("hold not at end of cycle");
   a_burst_wait_one: assert property (burst_wait_cycle |=> !burst_wait_cycle)
      else $error("burst wait longer than one");
   a_idle_then_addr: assert property ($fell(idle_phase) |-> addr_phase)
      else $error("idle not followed by address");
endmodule : bus_zone_chk

bind bus_zone_timing_config bus_zone_chk i_chk (.clk, .reset_n, .avs_read, .avs_write,
   .avs_waitrequest, .core_req, .core_zone, .core_done, .zone_one_chip_select,
   .addr_phase, .internal_wait_cycle, .burst_wait_cycle, .hold_phase, .idle_phase);

/* File: verification/mem_side_model.sv */
// mem_side_model: memory side that counts the phases of each bus cycle.
// assumes phase outputs are decoded per cycle and core_done ends a cycle.
`timescale 1ns/1ps
module mem_side_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic zone_one_chip_select,
   input  wire logic addr_phase,
   input  wire logic internal_wait_cycle,
   input  wire logic burst_wait_cycle,
   input  wire logic hold_phase,
   input  wire logic idle_phase,
   input  wire logic core_done,
   output logic [7:0] cnt [6],
   output logic       cs_seen
);
   logic [7:0] c [6];
   logic       c_cs;
   logic       busy_r;
   logic       any_ph;
   assign any_ph = addr_phase | internal_wait_cycle | burst_wait_cycle | hold_phase | idle_phase;
   // counts: idle, wait, hold, burst wait, address, length before done
   always_ff @(posedge clk) begin
      if (!reset_n || core_done) begin
         c <= '{default: 8'h00};
         c_cs <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         c[0] <= c[0] + 8'(idle_phase);
         c[1] <= c[1] + 8'(internal_wait_cycle);
         c[2] <= c[2] + 8'(hold_phase);
         c[3] <= c[3] + 8'(burst_wait_cycle);
         c[4] <= c[4] + 8'(addr_phase);
         c[5] <= c[5] + 8'(busy_r | any_ph);
         busy_r <= busy_r | any_ph;
         c_cs <= c_cs | zone_one_chip_select;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt <= '{default: 8'h00};
         cs_seen <= 1'b0;
      end else if (core_done) begin
         cnt <= c;
         cs_seen <= c_cs | zone_one_chip_select;
      end
   end
endmodule : mem_side_model

/* File: verification/tb_bus_zone_timing_config.sv */
// tb_bus_zone_timing_config: register and bus cycle tests of the block.
// assumes the Avalon-MM slave answers after one wait, as the design states.
`timescale 1ns/1ps
module tb_bus_zone_timing_config import bus_zone_pkg::*;;
   logic        clk;
   logic        reset_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        core_req;
   logic        core_write;
   logic        core_wide;
   logic [1:0]  core_zone;
   logic        core_done;
   logic        cs;
   logic        ph [5];
   logic [7:0]  cnt [6];
   logic        cs_seen;
   int          err_total;
   int          check_count;

   bus_zone_timing_config i_dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .core_req,
      .core_write, .core_wide, .core_zone, .core_done, .zone_one_chip_select(cs),
      .addr_phase(ph[0]), .internal_wait_cycle(ph[1]), .burst_wait_cycle(ph[2]),
      .hold_phase(ph[3]), .idle_phase(ph[4]));
   mem_side_model i_mem (.clk, .reset_n, .zone_one_chip_select(cs), .addr_phase(ph[0]),
      .internal_wait_cycle(ph[1]), .burst_wait_cycle(ph[2]), .hold_phase(ph[3]),
      .idle_phase(ph[4]), .core_done, .cnt, .cs_seen);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR time=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task automatic reg_acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      if (!wr) chk(avs_readdata, d);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : reg_acc
   // expectations packed as {idle,wait,hold,burst wait} and {0,address,length,cs}
   task automatic core_op(input logic [1:0] z, input logic wr, input logic [31:0] e0,
                          input logic [31:0] e1);
      @(posedge clk);
      core_req <= 1'b1;
      core_zone <= z;
      core_write <= wr;
      core_wide <= 1'b1;
      do @(posedge clk); while (core_done !== 1'b1);
      core_req <= 1'b0;
      @(negedge clk);
      chk({cnt[0], cnt[1], cnt[2], cnt[3]}, e0);
      chk({8'h00, cnt[4], cnt[5], 7'h00, cs_seen}, e1);
   endtask : core_op
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial begin
      #(20 * 5000);
      err_total++;
      summarize();
   end
   initial begin
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      {core_req, core_write, core_wide, core_zone} = '0;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      reg_acc(1'b0, OFS_WRITE_MODE, 32'h00000007);
      reg_acc(1'b0, OFS_IO_ZONE, 32'h0000069F);
      reg_acc(1'b0, OFS_FLASH_ZONE, 32'h0000069F);
      reg_acc(1'b0, OFS_EXT_ZONE, 32'h0000069F);
      reg_acc(1'b1, 5'h14, 32'hFFFFFFFF);
      reg_acc(1'b0, 5'h14, 32'h00000000);
      reg_acc(1'b1, OFS_IO_ZONE, 32'h0000FFFF);
      reg_acc(1'b0, OFS_IO_ZONE, 32'h00000EFF);
      reg_acc(1'b1, OFS_IO_ZONE, 32'h0000069F);
      reg_acc(1'b1, OFS_FLASH_ZONE, 32'h00000092);
      core_op(ZONE_FLASH, 1'b0, 32'h00020200, 32'h00010600);
      core_op(ZONE_FLASH, 1'b1, 32'h00020200, 32'h00010700);
      reg_acc(1'b1, OFS_WRITE_MODE, 32'h00000006);
      reg_acc(1'b0, OFS_WRITE_MODE, 32'h00000006);
      core_op(ZONE_FLASH, 1'b1, 32'h00020200, 32'h00010600);
      reg_acc(1'b1, OFS_FLASH_ZONE, 32'h00000892);
      core_op(ZONE_FLASH, 1'b0, 32'h00000000, 32'h00010100);
      core_op(ZONE_FLASH, 1'b1, 32'h00000000, 32'h00010200);
      reg_acc(1'b1, OFS_EXT_ZONE, 32'h00000661);
      core_op(ZONE_EXT, 1'b0, 32'h01020000, 32'h00020701);
      reg_acc(1'b1, OFS_EXT_ZONE, 32'h000006E1);
      core_op(ZONE_EXT, 1'b0, 32'h00010001, 32'h00010501);
      core_op(ZONE_IO, 1'b0, 32'h02070300, 32'h00010E00);
      core_op(ZONE_FLASH, 1'b0, 32'h01000000, 32'h00010200);
      // status: busy, last zone, last length without idle cycles
      reg_acc(1'b0, OFS_STATUS, 32'h00000001);
      core_op(ZONE_NONE, 1'b0, 32'h00000000, 32'h00010200);
      reg_acc(1'b0, OFS_STATUS, 32'h00000302);
      summarize();
   end
endmodule : tb_bus_zone_timing_config
